// ===== common/cmd_decoder_pkg.sv
`default_nettype none

package cmd_decoder_pkg;

    // register offsets on the serial register map
    localparam logic [7:0] STATUS_OFFSET       = 8'h00;
    localparam logic [7:0] DEVICE_SETUP_OFFSET = 8'h16;
    localparam logic [7:0] TEST_REG_A_OFFSET   = 8'h30;
    localparam logic [7:0] TEST_REG_B_OFFSET   = 8'h31;

    // command codes, each also a register offset
    localparam logic [7:0] CMD_SINGLE_ACQUIRE         = 8'hf0;
    localparam logic [7:0] CMD_NVM_ACCESS_ENTER       = 8'hf1;
    localparam logic [7:0] CMD_PROGRAM_USER_PAGE      = 8'hf2;
    localparam logic [7:0] CMD_PROGRAM_FACTORY_PAGE   = 8'hf3;
    localparam logic [7:0] CMD_NVM_READBACK           = 8'hf4;
    localparam logic [7:0] CMD_RETURN_NORMAL          = 8'hf5;

    // field positions
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NVM_BIT  = 1;
    localparam int SETUP_ROUTE_BIT = 2;

    // values after reset
    localparam logic [7:0] TEST_REG_RESET     = 8'h00;
    localparam logic [7:0] DEVICE_SETUP_RESET = 8'h00;

    // default bus address of this slave
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h30;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INT_PULSE_NS  = 1000;
    localparam int INT_PULSE_CYC =
        (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_CNT_W = 8;

endpackage

`default_nettype wire

// ===== src/i2c_command_decoder.sv
`default_nettype none

module i2c_command_decoder #(
    parameter logic [6:0] DEV_ADDR = cmd_decoder_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic scl_i,
    output var  logic scl_o,
    output var  logic scl_oe,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe,
    output var  logic int_pin,
    input  wire logic irq_event,
    input  wire logic user_lock,
    input  wire logic factory_lock,
    input  wire logic exec_done,
    output var  logic busy,
    output var  logic nvm_mode,
    output var  logic acquire_start,
    output var  logic prog_user_start,
    output var  logic prog_factory_start,
    output var  logic readback_start
);
    import cmd_decoder_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK
    } bus_state_t;

    typedef struct packed {
        logic [2:0]           scl_sync;
        logic [2:0]           sda_sync;
        bus_state_t           st;
        logic [3:0]           bitcnt;
        logic [7:0]           shift;
        logic [1:0]           byte_idx;
        logic                 rd;
        logic                 ack_ok;
        logic [7:0]           ptr;
        logic                 busy;
        logic                 self_done;
        logic                 nvm_mode;
        logic                 acq;
        logic                 prog_user;
        logic                 prog_fact;
        logic                 readback;
        logic [7:0]           test_a;
        logic [7:0]           test_b;
        logic [7:0]           setup;
        logic [INT_CNT_W-1:0] int_cnt;
        logic                 int_route;
        logic                 scl_oe;
        logic                 sda_oe;
        logic                 int_pin;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic cmd_addr;
    logic cmd_first;
    logic cmd_valid;
    logic cmd_hit;

    function automatic logic [7:0] read_byte(input state_t s,
                                             input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            STATUS_OFFSET: begin
                r[STATUS_BUSY_BIT] = s.busy;
                r[STATUS_NVM_BIT]  = s.nvm_mode;
            end
            DEVICE_SETUP_OFFSET: r = s.setup;
            TEST_REG_A_OFFSET:   r = s.test_a;
            TEST_REG_B_OFFSET:   r = s.test_b;
            default:             r = 8'h00;
        endcase
        return r;
    endfunction

    // only stage 1 and 2 feed logic; stage 0 is the metastable catcher
    assign scl_rise   = state_reg.scl_sync[1] & ~state_reg.scl_sync[2];
    assign scl_fall   = ~state_reg.scl_sync[1] & state_reg.scl_sync[2];
    assign start_cond = state_reg.scl_sync[1] & state_reg.scl_sync[2] &
                        ~state_reg.sda_sync[1] & state_reg.sda_sync[2];
    assign stop_cond  = state_reg.scl_sync[1] & state_reg.scl_sync[2] &
                        state_reg.sda_sync[1] & ~state_reg.sda_sync[2];
    assign cmd_addr   = (state_reg.ptr >= CMD_SINGLE_ACQUIRE) &&
                        (state_reg.ptr <= CMD_RETURN_NORMAL);
    assign cmd_first  = state_reg.st == ST_RX && scl_fall &&
                        state_reg.bitcnt == 4'h8 &&
                        state_reg.byte_idx == 2'h2 && cmd_addr;
    assign cmd_valid  = cmd_first && state_reg.shift == ~state_reg.ptr;
    // access-mode commands are dropped outside access mode
    assign cmd_hit    = cmd_valid &&
                        (state_reg.ptr == CMD_SINGLE_ACQUIRE ||
                         state_reg.ptr == CMD_NVM_ACCESS_ENTER ||
                         state_reg.ptr == CMD_RETURN_NORMAL ||
                         state_reg.nvm_mode);

    always_comb begin
        state_next           = state_reg;
        state_next.scl_sync  = {state_reg.scl_sync[1:0], scl_i};
        state_next.sda_sync  = {state_reg.sda_sync[1:0], sda_i};
        state_next.acq       = 1'b0;
        state_next.prog_user = 1'b0;
        state_next.prog_fact = 1'b0;
        state_next.readback  = 1'b0;
        state_next.self_done = 1'b0;

        case (state_reg.st)
            ST_RX: begin
                if (scl_rise) begin
                    state_next.shift  = {state_reg.shift[6:0],
                                         state_reg.sda_sync[1]};
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end else if (scl_fall && state_reg.bitcnt == 4'h8) begin
                    state_next.st     = ST_ACK;
                    state_next.sda_oe = 1'b1;
                    if (state_reg.byte_idx != 2'h3) begin
                        state_next.byte_idx = state_reg.byte_idx + 2'h1;
                    end
                    case (state_reg.byte_idx)
                        2'h0: begin
                            state_next.rd = state_reg.shift[0];
                            if (state_reg.shift[7:1] != DEV_ADDR) begin
                                state_next.st     = ST_IDLE;
                                state_next.sda_oe = 1'b0;
                            end
                        end
                        2'h1: state_next.ptr = state_reg.shift;
                        default: begin
                            // extra bytes at a command address fall here
                            if (!cmd_addr) begin
                                state_next.ptr = state_reg.ptr + 8'h01;
                                case (state_reg.ptr)
                                    DEVICE_SETUP_OFFSET:
                                        state_next.setup = state_reg.shift;
                                    TEST_REG_A_OFFSET:
                                        state_next.test_a = state_reg.shift;
                                    TEST_REG_B_OFFSET:
                                        state_next.test_b = state_reg.shift;
                                    default: ;
                                endcase
                            end
                        end
                    endcase
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    state_next.bitcnt = 4'h0;
                    if (state_reg.rd) begin
                        state_next.st    = ST_TX;
                        state_next.shift = read_byte(state_reg,
                                                     state_reg.ptr);
                        state_next.sda_oe = ~state_next.shift[7];
                    end else begin
                        state_next.st     = ST_RX;
                        state_next.sda_oe = 1'b0;
                    end
                end
            end
            ST_TX: begin
                if (scl_rise) begin
                    state_next.bitcnt = state_reg.bitcnt + 4'h1;
                end else if (scl_fall) begin
                    if (state_reg.bitcnt == 4'h8) begin
                        state_next.st     = ST_TXACK;
                        state_next.sda_oe = 1'b0;
                    end else begin
                        state_next.shift  = {state_reg.shift[6:0], 1'b0};
                        state_next.sda_oe = ~state_reg.shift[6];
                    end
                end
            end
            ST_TXACK: begin
                if (scl_rise) begin
                    state_next.ack_ok = ~state_reg.sda_sync[1];
                end else if (scl_fall) begin
                    state_next.bitcnt = 4'h0;
                    if (state_reg.ack_ok) begin
                        state_next.st     = ST_TX;
                        state_next.ptr    = state_reg.ptr + 8'h01;
                        state_next.shift  = read_byte(state_reg,
                                                 state_next.ptr);
                        state_next.sda_oe = ~state_next.shift[7];
                    end else begin
                        state_next.st = ST_IDLE;
                    end
                end
            end
            ST_IDLE: ;
            default: state_next.st = ST_IDLE;
        endcase

        if (start_cond) begin
            state_next.st       = ST_RX;
            state_next.bitcnt   = 4'h0;
            state_next.byte_idx = 2'h0;
            state_next.sda_oe   = 1'b0;
        end else if (stop_cond) begin
            state_next.st     = ST_IDLE;
            state_next.sda_oe = 1'b0;
        end

        // a new command wins over the completion of the previous one
        state_next.busy = state_reg.busy &
                          ~(exec_done | state_reg.self_done);
        if (cmd_hit) begin
            state_next.busy = 1'b1;
            case (state_reg.ptr)
                CMD_SINGLE_ACQUIRE: state_next.acq = 1'b1;
                CMD_NVM_ACCESS_ENTER: begin
                    state_next.nvm_mode  = 1'b1;
                    state_next.self_done = 1'b1;
                end
                CMD_PROGRAM_USER_PAGE: begin
                    state_next.prog_user = ~user_lock;
                    state_next.self_done = user_lock;
                end
                CMD_PROGRAM_FACTORY_PAGE: begin
                    state_next.prog_fact = ~factory_lock;
                    state_next.self_done = factory_lock;
                end
                CMD_NVM_READBACK: state_next.readback = 1'b1;
                CMD_RETURN_NORMAL: begin
                    state_next.nvm_mode = 1'b0;
                    state_next.readback = 1'b1;
                end
                default: state_next.busy = state_reg.busy;
            endcase
        end

        // the pulse is not held off during a frame; route it to the
        // dedicated pin if the bus may be busy when events occur
        if (state_reg.int_cnt != '0) begin
            state_next.int_cnt = state_reg.int_cnt - 1'b1;
        end else if (irq_event) begin
            state_next.int_cnt   = INT_CNT_W'(INT_PULSE_CYC);
            state_next.int_route = state_reg.setup[SETUP_ROUTE_BIT];
        end
        state_next.scl_oe  = (state_next.int_cnt != '0) &
                             state_next.int_route;
        state_next.int_pin = (state_next.int_cnt != '0) &
                             ~state_next.int_route;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.scl_sync <= 3'h7;
            state_reg.sda_sync <= 3'h7;
            state_reg.st       <= ST_IDLE;
            state_reg.test_a   <= TEST_REG_RESET;
            state_reg.test_b   <= TEST_REG_RESET;
            state_reg.setup    <= DEVICE_SETUP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign scl_o              = 1'b0;
    assign sda_o              = 1'b0;
    assign scl_oe             = state_reg.scl_oe;
    assign sda_oe             = state_reg.sda_oe;
    assign int_pin            = state_reg.int_pin;
    assign busy               = state_reg.busy;
    assign nvm_mode           = state_reg.nvm_mode;
    assign acquire_start      = state_reg.acq;
    assign prog_user_start    = state_reg.prog_user;
    assign prog_factory_start = state_reg.prog_fact;
    assign readback_start     = state_reg.readback;

    busy_set_a: assert property (cmd_hit |=> busy)
        else $error("busy not set after accepted command");
    busy_clear_a: assert property (
        busy && exec_done && !cmd_hit |=> !busy)
        else $error("busy not cleared on completion");
    acquire_go_a: assert property (
        cmd_hit && state_reg.ptr == CMD_SINGLE_ACQUIRE
        |=> acquire_start ##1 !acquire_start)
        else $error("acquisition start missing or too long");
    nvm_enter_a: assert property (
        cmd_hit && state_reg.ptr == CMD_NVM_ACCESS_ENTER
        |=> nvm_mode && busy ##1 !busy || $past(cmd_hit))
        else $error("access mode entry wrong");
    user_lock_a: assert property (
        prog_user_start |-> $past(!user_lock) && $past(nvm_mode))
        else $error("user page programmed while locked");
    factory_lock_a: assert property (
        prog_factory_start |-> $past(!factory_lock) && $past(nvm_mode))
        else $error("factory page programmed while locked");
    readback_go_a: assert property (
        cmd_hit && state_reg.ptr == CMD_NVM_READBACK |=> readback_start)
        else $error("readback not started");
    return_normal_a: assert property (
        cmd_hit && state_reg.ptr == CMD_RETURN_NORMAL
        |=> !nvm_mode && readback_start)
        else $error("return to normal incomplete");
    extra_byte_a: assert property (
        state_reg.st == ST_RX && scl_fall && state_reg.bitcnt == 4'h8 &&
        state_reg.byte_idx == 2'h3 && cmd_addr
        |=> !acquire_start && !readback_start && $stable(nvm_mode))
        else $error("extra command byte acted on");
    bad_code_a: assert property (
        cmd_first && !cmd_valid && !busy |=> !busy)
        else $error("invalid command set busy");
    test_quiet_a: assert property (
        $changed(state_reg.test_a) || $changed(state_reg.test_b)
        |-> $stable(nvm_mode) && !acquire_start)
        else $error("test register write disturbed operation");
    int_route_a: assert property (
        $rose(scl_oe) |-> $past(state_reg.setup[SETUP_ROUTE_BIT])
        && !int_pin)
        else $error("interrupt on clock line while not routed");

    acquire_seen_c: cover property (acquire_start);
    prog_user_seen_c: cover property (prog_user_start);
    bad_code_seen_c: cover property (cmd_first && !cmd_valid);
    scl_int_seen_c: cover property ($rose(scl_oe));

endmodule

`default_nettype wire

// ===== verification/i2c_host_model.sv
`default_nettype none

module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h30
) (
    output var  logic scl_out,
    output var  logic sda_out,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // quarter of the 125 ns bus clock period
    localparam real Q = 31.25;

    // a released line floats high through the bus pull-ups
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic start_c;
        sda_out = 1'b1;
        #Q scl_out = 1'b1;
        #(2 * Q) sda_out = 1'b0;
        #(2 * Q) scl_out = 1'b0;
        #Q;
    endtask

    task automatic stop_c;
        sda_out = 1'b0;
        #Q scl_out = 1'b1;
        #(2 * Q) sda_out = 1'b1;
        #(2 * Q);
    endtask

    // data moves only while the clock is low, sampled mid high phase
    task automatic bit_c(input logic b, output logic r);
        sda_out = b;
        #Q scl_out = 1'b1;
        #Q r = sda_line;
        #Q scl_out = 1'b0;
        #Q;
    endtask

    task automatic byte_c(input logic [7:0] d, output logic [7:0] r);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], b);
            r[i] = b;
        end
    endtask

    task automatic send(input logic [7:0] x, inout logic ok);
        logic [7:0] r;
        logic       b;
        byte_c(x, r);
        bit_c(1'b1, b);
        ok = ok & ~b;
    endtask

    task automatic wr(input logic [7:0] off, d0, d1, input int n,
                      output logic ok);
        ok = 1'b1;
        start_c;
        send({ADDR, 1'b0}, ok);
        send(off, ok);
        if (n > 0) send(d0, ok);
        if (n > 1) send(d1, ok);
        stop_c;
    endtask

    task automatic rd(input logic [7:0] off, output logic [7:0] d,
                      output logic ok);
        logic b;
        ok = 1'b1;
        start_c;
        send({ADDR, 1'b0}, ok);
        send(off, ok);
        start_c;
        send({ADDR, 1'b1}, ok);
        byte_c(8'hff, d);
        bit_c(1'b1, b);
        stop_c;
    endtask
endmodule

`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmd_decoder_pkg::*;

    logic sys_clk, rst_n, irq_event, user_lock, factory_lock, exec_done;
    logic scl_o, scl_oe, sda_o, sda_oe, int_pin, busy, nvm_mode;
    logic acquire_start, prog_user_start, prog_factory_start;
    logic readback_start, host_scl, host_sda, scl_line, sda_line, busy_q;
    int   fails, comparisons, n_acq, n_usr, n_fac, n_rb, n_bsy;

    // open-drain wiring: anyone pulling low wins
    assign scl_line = host_scl & ~scl_oe;
    assign sda_line = host_sda & ~sda_oe;

    i2c_command_decoder i2c_command_decoder_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl_line),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .int_pin(int_pin),
        .irq_event(irq_event), .user_lock(user_lock),
        .factory_lock(factory_lock), .exec_done(exec_done),
        .busy(busy), .nvm_mode(nvm_mode),
        .acquire_start(acquire_start),
        .prog_user_start(prog_user_start),
        .prog_factory_start(prog_factory_start),
        .readback_start(readback_start)
    );

    i2c_host_model i2c_host_model_inst (
        .scl_out(host_scl), .sda_out(host_sda), .sda_line(sda_line)
    );

    always #5 sys_clk = ~sys_clk;

    // pulse counters let a repeated start pulse show up as a count of 2
    always @(posedge sys_clk) begin
        n_acq += (acquire_start === 1'b1);
        n_usr += (prog_user_start === 1'b1);
        n_fac += (prog_factory_start === 1'b1);
        n_rb += (readback_start === 1'b1);
        n_bsy += (busy === 1'b1 && busy_q !== 1'b1);
        busy_q = busy;
    end

    task automatic check(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic w(input logic [7:0] off, d0, d1, input int n);
        logic ok;
        i2c_host_model_inst.wr(off, d0, d1, n, ok);
        check(ok, 1'h1);
    endtask

    task automatic r(input logic [7:0] off, exp);
        logic [7:0] d;
        logic       ok;
        i2c_host_model_inst.rd(off, d, ok);
        check({ok, d}, {1'b1, exp});
    endtask

    // exp nibbles: acquire, user, factory, readback, busy rises
    task automatic cmd(input logic [7:0] code, comp,
                       input logic [31:0] exp, input logic ex);
        int s[5];
        s = '{n_acq, n_usr, n_fac, n_rb, n_bsy};
        w(code, comp, comp, 2);
        repeat (5) @(posedge sys_clk);
        #1;
        check(((n_acq - s[0]) << 16) | ((n_usr - s[1]) << 12) |
              ((n_fac - s[2]) << 8) | ((n_rb - s[3]) << 4) |
              (n_bsy - s[4]), exp);
        check(busy, ex);
        if (ex) begin
            exec_done = 1'b1;
            @(posedge sys_clk);
            #1 exec_done = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 check(busy, 1'h0);
        end
    endtask

    task automatic t_regs;
        r(TEST_REG_A_OFFSET, TEST_REG_RESET);
        w(TEST_REG_A_OFFSET, 8'ha5, 8'h5a, 2);
        r(TEST_REG_A_OFFSET, 8'ha5);
        r(TEST_REG_B_OFFSET, 8'h5a);
        r(8'h40, 8'h00);
        check({busy, nvm_mode, int_pin, scl_o, sda_o}, 5'h00);
    endtask

    task automatic t_cmds;
        cmd(CMD_SINGLE_ACQUIRE, 8'h0f, 32'h0001_0001, 1'b1);
        cmd(CMD_SINGLE_ACQUIRE, 8'h00, 32'h0000_0000, 1'b0);
        cmd(CMD_PROGRAM_USER_PAGE, 8'h0d, 32'h0000_0000, 1'b0);
        cmd(CMD_NVM_ACCESS_ENTER, 8'h0e, 32'h0000_0001, 1'b0);
        check(nvm_mode, 1'h1);
        r(STATUS_OFFSET, 8'h02);
        cmd(CMD_PROGRAM_USER_PAGE, 8'h0d, 32'h0000_1001, 1'b1);
        user_lock = 1'b1;
        cmd(CMD_PROGRAM_USER_PAGE, 8'h0d, 32'h0000_0001, 1'b0);
        cmd(CMD_PROGRAM_FACTORY_PAGE, 8'h0c, 32'h0000_0101, 1'b1);
        factory_lock = 1'b1;
        cmd(CMD_PROGRAM_FACTORY_PAGE, 8'h0c, 32'h0000_0001, 1'b0);
        cmd(CMD_NVM_READBACK, 8'h0b, 32'h0000_0011, 1'b1);
        cmd(CMD_RETURN_NORMAL, 8'h0a, 32'h0000_0011, 1'b1);
        check(nvm_mode, 1'h0);
    endtask

    task automatic irq_len(input logic route);
        int k;
        k = 0;
        @(posedge sys_clk);
        #1 irq_event = 1'b1;
        @(posedge sys_clk);
        #1 irq_event = 1'b0;
        check({scl_oe, int_pin, scl_line}, route ? 3'h4 : 3'h3);
        while ((scl_oe | int_pin) === 1'b1 && k < 300) begin
            @(posedge sys_clk);
            #1 k++;
        end
        check(k, INT_PULSE_CYC);
    endtask

    task automatic t_irq;
        irq_len(1'b0);
        w(DEVICE_SETUP_OFFSET, 8'h04, 8'h00, 1);
        irq_len(1'b1);
    endtask

    // the scenarios need about 100 us of bus traffic; margin of three
    initial begin
        #300_000;
        fails++;
        end_sim;
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        irq_event = 1'b0;
        user_lock = 1'b0;
        factory_lock = 1'b0;
        exec_done = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs;
        t_cmds;
        t_irq;
        end_sim;
    end
endmodule

`default_nettype wire
